/* File: src/tsp_timer.sv */
// Eight-bit timer/counter with shared prescaler behind an APB slave
//
// Contract
// - Source select 0 counts instruction cycles
// - Counter write blocks increments for two instruction cycles
// - Source select 1 counts count-pin transitions
// - Edge select 0 rising, 1 falling
// - Wrap FFh to 00h sets overflow flag
// - Interrupt request only while overflow enable set
// - Sleep halts the counter completely
// - Unassigned prescaler passes count pin straight
// - Prescaler output sampled at phases two, four
// - Option bit 7 disables all pull-ups
// - Option bit 6 picks external interrupt edge
// - Assign bit picks watchdog or counter
// - Rate field divides, doubling per code
// - Prescaler is hidden eight-bit counter
// - Counter write clears assigned prescaler
// - Watchdog clear clears watchdog, and prescaler only while assigned to it
// - Counter lives at index 01h, read/write
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module tsp_timer #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extCountPin,
  input wire logic wdtOscPin,
  output logic irqRequest,
  output logic pullupGlobalOff,
  output logic extIrqRising,
  output logic wdtTick,
  output logic wdtClear
);
  // Whole module state
  typedef struct packed {
    logic [1:0] phase;       // Q1..Q4 of the instruction cycle
    logic pinMeta;           // Count pin, first sync stage
    logic pinSync;           // Count pin, second sync stage
    logic pinXPrev;          // Last polarity-adjusted pin level
    logic wdtMeta;           // Watchdog clock, first stage
    logic wdtSync;           // Watchdog clock, second stage
    logic wdtPrev;           // Last watchdog clock level
    logic sampleLvl;         // Prescaler output seen at Q2/Q4
    logic [7:0] tick;        // Counter value
    logic [7:0] intctl;      // Interrupt control
    logic [7:0] option;      // Option register
    logic sleep;             // Core sleeping
    logic [1:0] inhibit;     // Instructions left without increments
    logic ready;             // APB ready
    logic err;               // APB error
    logic [31:0] rdata;      // APB read data
    logic irq;               // Interrupt request
    logic pullOff;           // Global pull-up disable
    logic irqRise;           // External interrupt edge
    logic wdtTick;           // Watchdog time base pulse
    logic wdtClr;            // Watchdog clear pulse
  } tsp_state_type;

  tsp_state_type s_q;
  tsp_state_type s_d;
  logic [1:0] rstPipe_q;     // Reset release synchroniser
  logic rstSync;             // Released reset for the design
  logic [tsp_pkg::PRESC_W-1:0] prescCnt;
  logic prescClear;
  logic prescAdvance;

  // Reset is asserted at once and released after two edges
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstSync = rstPipe_q[1];

  // Decoded fields and events
  logic [tsp_pkg::IDX_W-1:0] idx;
  logic mapped;
  logic accessDone;
  logic busWr;
  logic wrTick;
  logic wdtClrReq;
  logic srcPin;
  logic assignWdt;
  logic [2:0] rate;
  logic instrTick;
  logic sampleNow;
  logic pinX;
  logic pinXRise;
  logic wdtEvent;
  logic prescOut;
  logic sampleRise;
  logic incEvent;
  logic doInc;
  logic ovfSet;
  logic [7:0] wdtMask;
  logic [tsp_pkg::PRESC_W-1:0] prescNext;
  logic [31:0] readVal;

  // Hidden prescaler; software has no path to its count
  tsp_prescaler #(
    .WIDTH(tsp_pkg::PRESC_W)
  ) u_presc (
    .clk_sys(clk_sys),
    .rstSync(rstSync),
    .clear(prescClear),
    .advance(prescAdvance),
    .count(prescCnt)
  );

  // Next-state logic
  always_comb begin
    s_d = s_q;
    idx = paddr[tsp_pkg::IDX_W+1:2];
    // Word-aligned index decode; anything else is an error
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (idx == tsp_pkg::IDX_TICK) begin
      mapped = 1'b1;
    end else if (idx == tsp_pkg::IDX_INTCTL) begin
      mapped = 1'b1;
    end else if (idx == tsp_pkg::IDX_OPTION) begin
      mapped = 1'b1;
    end else if (idx == tsp_pkg::IDX_CORE) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
    accessDone = psel && penable && s_q.ready;
    busWr = accessDone && pwrite && !s_q.err && pstrb[0];
    wrTick = busWr && (idx == tsp_pkg::IDX_TICK);
    wdtClrReq = busWr && (idx == tsp_pkg::IDX_CORE) && pwdata[tsp_pkg::CORE_WDT_CLR_BIT];
    srcPin = s_q.option[tsp_pkg::OPT_SRC_BIT];
    assignWdt = s_q.option[tsp_pkg::OPT_ASSIGN_BIT];
    rate = s_q.option[tsp_pkg::OPT_RATE_MSB:tsp_pkg::OPT_RATE_LSB];
    // Phase clocks
    s_d.phase = s_q.phase + 2'h1;
    instrTick = (s_q.phase == tsp_pkg::PHASE_FOUR);
    sampleNow = (s_q.phase == tsp_pkg::PHASE_TWO) || instrTick;
    // Pins pass two stages before any use
    s_d.pinMeta = extCountPin;
    s_d.pinSync = s_q.pinMeta;
    s_d.wdtMeta = wdtOscPin;
    s_d.wdtSync = s_q.wdtMeta;
    s_d.wdtPrev = s_q.wdtSync;
    wdtEvent = s_q.wdtSync && !s_q.wdtPrev;
    // Inverting the pin turns falling edges into rising ones
    pinX = s_q.pinSync ^ s_q.option[tsp_pkg::OPT_EDGE_BIT];
    s_d.pinXPrev = pinX;
    pinXRise = pinX && !s_q.pinXPrev;
    // Prescaler source follows its owner
    if (assignWdt) begin
      prescAdvance = wdtEvent;
      prescClear = wdtClrReq;
    end else begin
      prescAdvance = !s_q.sleep && (srcPin ? pinXRise : instrTick);
      prescClear = wrTick;
    end
    // Timer tap: bit n toggles every 2^n inputs, rising every 2^(n+1)
    prescOut = assignWdt ? pinX : prescCnt[rate];
    // Level seen only at Q2 and Q4, costing up to one phase of latency
    if (sampleNow) begin
      s_d.sampleLvl = prescOut;
    end
    sampleRise = sampleNow && prescOut && !s_q.sampleLvl;
    // Bypassed timer mode counts instructions directly
    incEvent = (assignWdt && !srcPin) ? instrTick : sampleRise;
    doInc = incEvent && !s_q.sleep && (s_q.inhibit == 2'h0) && !wrTick;
    ovfSet = doInc && (s_q.tick == 8'hFF);
    // Inhibit window after a software write
    if (wrTick) begin
      s_d.inhibit = tsp_pkg::INHIBIT_INSTRS;
    end else if (instrTick && (s_q.inhibit != 2'h0)) begin
      s_d.inhibit = s_q.inhibit - 2'h1;
    end
    // Counter: write wins, else free-running wrap
    if (wrTick) begin
      s_d.tick = pwdata[7:0];
    end else if (doInc) begin
      s_d.tick = s_q.tick + 8'h01;
    end
    // Register writes
    if (busWr && (idx == tsp_pkg::IDX_INTCTL)) begin
      s_d.intctl = pwdata[7:0];
    end
    if (busWr && (idx == tsp_pkg::IDX_OPTION)) begin
      s_d.option = pwdata[7:0];
    end
    if (busWr && (idx == tsp_pkg::IDX_CORE)) begin
      s_d.sleep = pwdata[tsp_pkg::CORE_SLEEP_BIT];
    end
    // Hardware set beats a software clear in the same cycle
    if (ovfSet) begin
      s_d.intctl[tsp_pkg::INT_OVF_FLAG_BIT] = 1'b1;
    end
    // Watchdog time base: rate 0 passes every input
    wdtMask = ~(8'hFF << rate);
    prescNext = prescCnt + 8'h01;
    if (assignWdt) begin
      s_d.wdtTick = wdtEvent && ((prescNext & wdtMask) == 8'h00);
    end else begin
      s_d.wdtTick = wdtEvent;
    end
    s_d.wdtClr = wdtClrReq;
    // Side outputs of the option register, and the interrupt request
    s_d.pullOff = s_d.option[tsp_pkg::OPT_PULLUP_OFF_BIT];
    s_d.irqRise = s_d.option[tsp_pkg::OPT_IRQ_EDGE_BIT];
    s_d.irq = s_d.intctl[tsp_pkg::INT_OVF_FLAG_BIT] && s_d.intctl[tsp_pkg::INT_OVF_EN_BIT];
    // Read mux, bits above the register read as zero
    if (idx == tsp_pkg::IDX_TICK) begin
      readVal = {24'h000000, s_q.tick};
    end else if (idx == tsp_pkg::IDX_INTCTL) begin
      readVal = {24'h000000, s_q.intctl};
    end else if (idx == tsp_pkg::IDX_OPTION) begin
      readVal = {24'h000000, s_q.option};
    end else if (idx == tsp_pkg::IDX_CORE) begin
      readVal = {31'h00000000, s_q.sleep};
    end else begin
      readVal = 32'h00000000;
    end
    // One wait-free access phase: ready rises with it
    s_d.ready = psel && !penable;
    s_d.err = psel && !penable && !mapped;
    if (psel && !penable) begin
      s_d.rdata = (mapped && !pwrite) ? readVal : 32'h00000000;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      // Edge history starts at the idle level seen through the reset edge select:
      // a low pin inverted reads high, so no phantom count follows reset
      s_q <= '{phase: 2'h0, pinMeta: 1'b0, pinSync: 1'b0,
               pinXPrev: tsp_pkg::OPTION_RESET[tsp_pkg::OPT_EDGE_BIT],
               wdtMeta: 1'b0, wdtSync: 1'b0, wdtPrev: 1'b0,
               sampleLvl: tsp_pkg::OPTION_RESET[tsp_pkg::OPT_EDGE_BIT],
               tick: tsp_pkg::TICK_RESET, intctl: tsp_pkg::INTCTL_RESET,
               option: tsp_pkg::OPTION_RESET, sleep: 1'b0, inhibit: 2'h0,
               ready: 1'b0, err: 1'b0, rdata: 32'h00000000, irq: 1'b0,
               pullOff: 1'b1, irqRise: 1'b1, wdtTick: 1'b0, wdtClr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign irqRequest = s_q.irq;
  assign pullupGlobalOff = s_q.pullOff;
  assign extIrqRising = s_q.irqRise;
  assign wdtTick = s_q.wdtTick;
  assign wdtClear = s_q.wdtClr;

  // Checks on the block's own state and outputs
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstSync);

  overflow_sets_a: assert property (ovfSet |=> s_q.intctl[tsp_pkg::INT_OVF_FLAG_BIT] && s_q.tick == 8'h00)
    else $error("overflow did not set flag");
  irq_masking_a: assert property (irqRequest == (s_q.intctl[tsp_pkg::INT_OVF_FLAG_BIT]
      && s_q.intctl[tsp_pkg::INT_OVF_EN_BIT]))
    else $error("interrupt request not gated by enable");
  write_inhibit_a: assert property (wrTick ##1 (!busWr)[*4] |-> $stable(s_q.tick))
    else $error("counter moved inside write inhibit");
  write_loads_a: assert property (wrTick |=> s_q.tick == $past(pwdata[7:0]) && s_q.inhibit == 2'h2)
    else $error("counter write not taken");
  sleep_halt_a: assert property (s_q.sleep && !wrTick |=> $stable(s_q.tick))
    else $error("counter moved during sleep");
  timer_step_a: assert property (!srcPin && assignWdt && instrTick && !s_q.sleep && s_q.inhibit == 2'h0
      && !wrTick |=> s_q.tick == $past(s_q.tick) + 8'h01)
    else $error("timer mode missed an instruction cycle");
  pin_bypass_a: assert property (assignWdt && srcPin && sampleRise && !s_q.sleep
      && s_q.inhibit == 2'h0 && !wrTick |=> s_q.tick == $past(s_q.tick) + 8'h01)
    else $error("bypassed pin edge not counted");
  phase_sample_a: assert property (!sampleNow |=> $stable(s_q.sampleLvl))
    else $error("sample taken outside phases two and four");
  presc_wr_clear_a: assert property (wrTick && !assignWdt |=> prescCnt == 8'h00)
    else $error("counter write left prescaler running");
  wdt_clear_a: assert property (wdtClrReq && assignWdt |=> prescCnt == 8'h00 && wdtClear)
    else $error("watchdog clear missed prescaler");
  flag_sticky_a: assert property (s_q.intctl[tsp_pkg::INT_OVF_FLAG_BIT]
      && !(busWr && idx == tsp_pkg::IDX_INTCTL) |=> s_q.intctl[tsp_pkg::INT_OVF_FLAG_BIT])
    else $error("overflow flag dropped by itself");
  option_outs_a: assert property (busWr && idx == tsp_pkg::IDX_OPTION |=> pullupGlobalOff == $past(pwdata[7])
      && extIrqRising == $past(pwdata[6]))
    else $error("option side outputs wrong");
endmodule : tsp_timer

/* File: src/tsp_pkg.sv */
// Constants shared by the shared-prescaler timer block
package tsp_pkg;
  // Register index width; byte address is four times the index
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_TICK = 10'h001;
  localparam logic [IDX_W-1:0] IDX_CORE = 10'h002;
  localparam logic [IDX_W-1:0] IDX_INTCTL = 10'h00B;
  localparam logic [IDX_W-1:0] IDX_OPTION = 10'h081;
  // Interrupt control fields
  localparam int INT_OVF_EN_BIT = 5;
  localparam int INT_OVF_FLAG_BIT = 2;
  // Option register fields
  localparam int OPT_PULLUP_OFF_BIT = 7;
  localparam int OPT_IRQ_EDGE_BIT = 6;
  localparam int OPT_SRC_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_ASSIGN_BIT = 3;
  localparam int OPT_RATE_MSB = 2;
  localparam int OPT_RATE_LSB = 0;
  // Core control fields
  localparam int CORE_SLEEP_BIT = 0;
  localparam int CORE_WDT_CLR_BIT = 1;
  // Reset values
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] TICK_RESET = 8'h00;
  // Instruction cycle timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLKS_PER_INSTR = 4;
  localparam logic [1:0] PHASE_TWO = 2'h1;
  localparam logic [1:0] PHASE_FOUR = 2'h3;
  localparam logic [1:0] INHIBIT_INSTRS = 2'h2;
  // Prescaler width
  localparam int PRESC_W = 8;
endpackage : tsp_pkg

/* File: src/tsp_prescaler.sv */
// Shared eight-bit prescaler counter, hidden from software
`timescale 1ns/1ps
module tsp_prescaler #(
  parameter int WIDTH = tsp_pkg::PRESC_W
) (
  input wire logic clk_sys,
  input wire logic rstSync,
  input wire logic clear,
  input wire logic advance,
  output logic [WIDTH-1:0] count
);
  // Whole module state
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } tsp_presc_type;

  tsp_presc_type s_q;
  tsp_presc_type s_d;

  // Clear beats advance so a clearing write starts from zero
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d.cnt = '0;
    end else if (advance) begin
      s_d.cnt = s_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstSync) begin
    if (!rstSync) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
endmodule : tsp_prescaler

/* File: tb/tsp_pin_src.sv */
// External count source driving whole pulse trains on the count pin
`timescale 1ns/1ps
module tsp_pin_src (
  input wire logic clk_sys,
  input wire logic start,
  input wire logic [7:0] pulses,
  output logic extCountPin,
  output logic busy
);
  // Four clocks per level, above the two-oscillator-period minimum
  localparam int HOLD = 4;
  // Pin idles low between trains; one train per start request, changed only after rising edges
  initial begin
    extCountPin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (start === 1'b1) begin
        busy <= 1'b1;
        for (int i = 0; i < pulses; i++) begin
          extCountPin <= 1'b1;
          repeat (HOLD) @(posedge clk_sys);
          extCountPin <= 1'b0;
          repeat (HOLD) @(posedge clk_sys);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule : tsp_pin_src

/* File: tb/timer8_shared_prescaler_tb.sv */
// Self-checking bench for the shared-prescaler timer
`timescale 1ns/1ps
module timer8_shared_prescaler_tb;
  localparam logic [11:0] A_TICK = {tsp_pkg::IDX_TICK, 2'h0};
  localparam logic [11:0] A_CORE = {tsp_pkg::IDX_CORE, 2'h0};
  localparam logic [11:0] A_INT = {tsp_pkg::IDX_INTCTL, 2'h0};
  localparam logic [11:0] A_OPT = {tsp_pkg::IDX_OPTION, 2'h0};
  logic clk_sys, rstn, psel, penable, pwrite, extCountPin, wdtOscPin, start, busy, err;
  logic pready, pslverr, irqRequest, pullupGlobalOff, extIrqRising, wdtTick, wdtClear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, t0;
  logic [3:0] pstrb;
  logic [7:0] pulses;
  int errors, totalChecks, ticks, clears, n0, oscCnt;

  tsp_timer dut_u (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extCountPin(extCountPin), .wdtOscPin(wdtOscPin), .irqRequest(irqRequest),
    .pullupGlobalOff(pullupGlobalOff), .extIrqRising(extIrqRising), .wdtTick(wdtTick), .wdtClear(wdtClear));
  tsp_pin_src src_u (.clk_sys(clk_sys), .start(start), .pulses(pulses), .extCountPin(extCountPin), .busy(busy));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Watchdog oscillator (rising edge every 8 clocks) and pulse counters
  always @(posedge clk_sys) begin
    oscCnt <= oscCnt + 1;
    wdtOscPin <= oscCnt[2];
    if (wdtTick === 1'b1) ticks <= ticks + 1;
    if (wdtClear === 1'b1) clears <= clears + 1;
  end
  // Hang guard, far beyond the few thousand cycles needed
  initial begin
    #100000;
    errors++;
    end_sim();
  end

  task end_sim;
    $display("checks %0d errors %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Range check for counts whose phase is not pinned down
  task rng(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    chk({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : rng
  task w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : w
  // One APB transfer; an idle cycle follows so no signal is set twice at one edge
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the hang guard ends this
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task t_reset;
    apb(1'b0, A_TICK, 8'h00);
    chk(q, 32'h0);
    apb(1'b0, A_OPT, 8'h00);
    chk(q, 32'h000000FF);
    apb(1'b0, A_INT, 8'h00);
    chk(q, 32'h0);
    chk({30'h0, pullupGlobalOff, extIrqRising}, 32'h3);
    apb(1'b0, 12'h010, 8'h00);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h005, 8'h00);
    chk({31'h0, err}, 32'h1);
  endtask : t_reset
  task t_option;
    logic [7:0] v;
    for (int i = 0; i < 2; i++) begin
      v = 8'h40 << i;
      apb(1'b1, A_OPT, v);
      w(2);
      chk({30'h0, pullupGlobalOff, extIrqRising}, {30'h0, v[7], v[6]});
    end
  endtask : t_option
  task t_timer;
    apb(1'b1, A_CORE, 8'h02);
    apb(1'b1, A_TICK, 8'h00);
    apb(1'b1, A_OPT, 8'h08);
    apb(1'b1, A_TICK, 8'h10);
    // The four clocks before the read hold exactly one instruction tick, which the inhibit swallows
    w(3);
    apb(1'b0, A_TICK, 8'h00);
    chk(q, 32'h10);
    w(16);
    apb(1'b0, A_TICK, 8'h00);
    t0 = q;
    w(80);
    apb(1'b0, A_TICK, 8'h00);
    rng(q[7:0] - t0[7:0], 8'h13, 8'h16);
  endtask : t_timer
  task t_presc;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, A_OPT, 8'(r));
      apb(1'b1, A_TICK, 8'h00);
      w(16);
      apb(1'b0, A_TICK, 8'h00);
      t0 = q;
      w((8 << r) * 8);
      apb(1'b0, A_TICK, 8'h00);
      rng(q[7:0] - t0[7:0], 8'h07, 8'h09);
    end
  endtask : t_presc
  task t_overflow;
    apb(1'b1, A_CORE, 8'h02);
    apb(1'b1, A_TICK, 8'h00);
    apb(1'b1, A_OPT, 8'h08);
    apb(1'b1, A_INT, 8'h00);
    apb(1'b1, A_TICK, 8'hFE);
    w(24);
    apb(1'b0, A_INT, 8'h00);
    chk(q, 32'h04);
    chk({31'h0, irqRequest}, 32'h0);
    apb(1'b1, A_INT, 8'h24);
    w(2);
    chk({31'h0, irqRequest}, 32'h1);
    apb(1'b1, A_INT, 8'h04);
    w(2);
    chk({31'h0, irqRequest}, 32'h0);
    apb(1'b0, A_INT, 8'h00);
    chk(q, 32'h04);
    apb(1'b0, A_TICK, 8'h00);
    rng(q[7:0], 8'h01, 8'h10);
    apb(1'b1, A_INT, 8'h00);
    apb(1'b0, A_INT, 8'h00);
    chk(q, 32'h0);
  endtask : t_overflow
  // Pin counting on both edges with the prescaler bypassed, then rising edges through it at 1:2
  task t_count;
    for (int e = 0; e < 3; e++) begin
      pulses <= (e == 2) ? 8'h06 : 8'h05;
      apb(1'b1, A_OPT, (e == 2) ? 8'h20 : (8'h28 | 8'(e << 4)));
      w(8);
      apb(1'b1, A_TICK, 8'h00);
      w(12);
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      for (int k = 0; k < 200; k++) begin
        @(posedge clk_sys);
        if (busy === 1'b0) break;
      end
      w(8);
      apb(1'b0, A_TICK, 8'h00);
      chk(q, (e == 2) ? 32'h3 : 32'h5);
    end
  endtask : t_count
  task t_sleep;
    apb(1'b1, A_OPT, 8'h08);
    apb(1'b1, A_CORE, 8'h01);
    apb(1'b0, A_TICK, 8'h00);
    t0 = q;
    w(40);
    apb(1'b0, A_TICK, 8'h00);
    chk(q, t0);
    apb(1'b1, A_CORE, 8'h00);
  endtask : t_sleep
  task t_wdt;
    apb(1'b1, A_OPT, 8'h09);
    w(8);
    n0 = ticks;
    w(320);
    rng(8'(ticks - n0), 8'h13, 8'h15);
    n0 = clears;
    apb(1'b1, A_CORE, 8'h02);
    w(3);
    chk(32'(clears - n0), 32'h1);
    apb(1'b0, A_CORE, 8'h00);
    chk(q, 32'h0);
  endtask : t_wdt

  // Reset, then each scenario in turn
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    start = 1'b0;
    pulses = 8'h05;
    wdtOscPin = 1'b0;
    errors = 0;
    totalChecks = 0;
    ticks = 0;
    clears = 0;
    oscCnt = 0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    w(3);
    t_reset();
    t_option();
    t_timer();
    t_presc();
    t_overflow();
    t_count();
    t_sleep();
    t_wdt();
    end_sim();
  end
endmodule : timer8_shared_prescaler_tb
